// ### rtl/tgc_timer.sv
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module tgc_timer
  import tgc_pkg::*;
#(
  parameter int CNT_SRCS = 17,
  parameter int GATE_SRCS = 27
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // register bus
  input wire tgc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock and gate sources, indexed by select code
  input wire logic [CNT_SRCS-1:0] count_src_in,
  input wire logic [GATE_SRCS-1:0] gate_src_in,
  // system
  input wire logic sleep_in,
  input wire logic special_event_in,
  // time base and events
  output logic [15:0] count_out,
  output logic overflow_pulse,
  output logic irq,
  output logic wake
);

  tgc_state_t q, d;

  logic setup, acc_wr, acc_rd;
  logic src_raw, src_edge, sys_src, tick_src, run_ok, count_en;
  logic g_sel, g_pol, g_t, g_rise, g_fall, gate_eff;
  logic wr_l, wr_h, pre_clr, hit;
  logic [7:0] wb;
  logic [31:0] rd;

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign count_out = q.cnt_o;
  assign overflow_pulse = q.ovf_pulse;
  assign irq = q.irq;
  assign wake = q.wake;

  always_comb begin
    d = q;
    wb = apb_req.pwdata[7:0];
    setup = apb_req.psel & ~apb_req.penable;
    acc_wr = apb_req.psel & apb_req.penable & q.pready & apb_req.pwrite;
    acc_rd = apb_req.psel & apb_req.penable & q.pready & ~apb_req.pwrite;

    // ------------------------------------------------------------
    // count clock source
    // ------------------------------------------------------------
    src_raw = 1'b0;
    if (q.cs <= TGC_CS_LAST && int'(q.cs) < CNT_SRCS) begin
      src_raw = count_src_in[q.cs];
    end
    d.clk_s1 = src_raw;
    d.clk_s2 = q.clk_s1;
    d.clk_sprev = q.clk_s2;
    d.clk_aprev = src_raw;
    d.div4 = q.div4 + 2'h1;
    src_edge = 1'b0;
    sys_src = 1'b1;
    tick_src = 1'b0;
    unique case (q.cs)
      TGC_CS_FOSC: tick_src = 1'b1;
      TGC_CS_FOSC4: tick_src = (q.div4 == TGC_DIV4_LAST);
      default: begin
        sys_src = 1'b0;
        if (q.sync) begin
          src_edge = src_raw & ~q.clk_aprev;
        end else begin
          src_edge = q.clk_s2 & ~q.clk_sprev;
        end
        tick_src = src_edge;
      end
    endcase
    // only async pin or secondary oscillator run in sleep
    run_ok = ~sleep_in | (q.sync & ~sys_src &
             (q.cs == TGC_CS_PIN || q.cs == TGC_CS_SOSC));

    // ------------------------------------------------------------
    // gate path
    // ------------------------------------------------------------
    g_sel = 1'b0;
    if (q.gate_source_field <= TGC_GS_LAST && int'(q.gate_source_field) < GATE_SRCS) begin
      g_sel = gate_src_in[q.gate_source_field];
    end
    g_pol = q.gate_polarity ? g_sel : ~g_sel;
    d.gate_polarity_prev = g_pol;
    if (!q.gate_toggle_mode) begin
      d.tgl = 1'b0;
    end else if (g_pol & ~q.gate_polarity_prev) begin
      d.tgl = ~q.tgl;
    end
    g_t = q.gate_toggle_mode ? q.tgl : g_pol;
    d.gt_prev = g_t;
    g_rise = g_t & ~q.gt_prev;
    g_fall = ~g_t & q.gt_prev;
    gate_eff = g_t;
    if (q.gate_single_pulse_mode) begin
      unique case (q.sp)
        TGC_SP_IDLE: gate_eff = 1'b0;
        TGC_SP_ARMED: begin
          gate_eff = 1'b0;
          if (g_rise) begin
            d.sp = TGC_SP_RUN;
            gate_eff = 1'b1;
          end
        end
        TGC_SP_RUN: begin
          gate_eff = g_t;
          if (g_fall) begin
            d.sp = TGC_SP_IDLE;
          end
        end
        default: d.sp = TGC_SP_IDLE;
      endcase
    end
    d.gate_level_status = gate_eff;

    // ------------------------------------------------------------
    // counter and prescaler
    // ------------------------------------------------------------
    count_en = q.on & (~q.ge | q.gate_level_status) & run_ok & tick_src;
    hit = 1'b0;
    if (count_en) begin
      if (q.pre == tgc_pre_last(q.ps)) begin
        d.pre = 3'h0;
        hit = 1'b1;
      end else begin
        d.pre = q.pre + 3'h1;
      end
    end
    d.ovf_pulse = 1'b0;
    if (hit) begin
      d.cnt = q.cnt + 16'h0001;
      if (q.cnt == TGC_CNT_MAX) begin
        d.ovf_pulse = 1'b1;
      end
    end
    if (special_event_in) begin
      d.cnt = TGC_CNT_ZERO;
      d.ovf_pulse = 1'b0;
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    wr_l = acc_wr && apb_req.paddr == TGC_A_CNTL;
    wr_h = acc_wr && apb_req.paddr == TGC_A_CNTH;
    pre_clr = wr_l | (wr_h & ~q.wide);
    if (pre_clr) begin
      d.pre = 3'h0;
    end
    if (wr_l) begin
      d.cnt = q.wide ? {q.hbuf, wb} : {q.cnt[15:8], wb};
      d.ovf_pulse = 1'b0;
    end
    if (wr_h) begin
      if (q.wide) begin
        d.hbuf = wb;
      end else begin
        d.cnt = {wb, q.cnt[7:0]};
        d.ovf_pulse = 1'b0;
      end
    end
    if (acc_wr) begin
      unique case (apb_req.paddr)
        TGC_A_CON: begin
          d.ps = wb[TGC_B_PS +: 2];
          d.sync = wb[TGC_B_SYNC];
          d.wide = wb[TGC_B_WIDE];
          d.on = wb[TGC_B_ON];
        end
        TGC_A_GCON: begin
          d.ge = wb[TGC_B_GE];
          d.gate_polarity = wb[TGC_B_GATE_POLARITY];
          d.gate_toggle_mode = wb[TGC_B_GTM];
          d.gate_single_pulse_mode = wb[TGC_B_GATE_SINGLE_PULSE_MODE];
          if (!wb[TGC_B_GATE_SINGLE_PULSE_MODE]) begin
            d.sp = TGC_SP_IDLE;
          end else if (wb[TGC_B_ARMED] && q.sp == TGC_SP_IDLE) begin
            d.sp = TGC_SP_ARMED;
          end else if (!wb[TGC_B_ARMED]) begin
            d.sp = TGC_SP_IDLE;
          end
        end
        TGC_A_CLK: d.cs = wb[4:0];
        TGC_A_GATE: d.gate_source_field = wb[4:0];
        TGC_A_IEN: begin
          d.oie = wb[TGC_B_OVF];
          d.gie = wb[TGC_B_GIF];
          d.glob = wb[TGC_B_GLOB];
        end
        TGC_A_MISC: d.md = wb[TGC_B_MD];
        default: ;
      endcase
    end
    if (!d.gate_single_pulse_mode) begin
      d.sp = TGC_SP_IDLE;
    end

    // ------------------------------------------------------------
    // flags: write one to clear, a new event wins
    // ------------------------------------------------------------
    if (acc_wr && apb_req.paddr == TGC_A_FLAG) begin
      if (wb[TGC_B_OVF]) begin
        d.ovf = 1'b0;
      end
      if (wb[TGC_B_GIF]) begin
        d.gif = 1'b0;
      end
    end
    if (d.ovf_pulse) begin
      d.ovf = 1'b1;
    end
    if (q.gate_level_status & ~d.gate_level_status) begin
      d.gif = 1'b1;
    end

    // ------------------------------------------------------------
    // register reads, taken in the setup cycle
    // ------------------------------------------------------------
    rd = 32'h00000000;
    d.pslverr = 1'b0;
    unique case (apb_req.paddr)
      TGC_A_CON: rd = tgc_byte({2'h0, q.ps, 1'b0, q.sync, q.wide, q.on});
      TGC_A_GCON: rd = tgc_byte({q.ge, q.gate_polarity, q.gate_toggle_mode, q.gate_single_pulse_mode,
                                 q.sp != TGC_SP_IDLE, q.gate_level_status, 2'h0});
      TGC_A_CLK: rd = tgc_byte({3'h0, q.cs});
      TGC_A_GATE: rd = tgc_byte({3'h0, q.gate_source_field});
      TGC_A_CNTL: rd = tgc_byte(q.cnt[7:0]);
      TGC_A_CNTH: rd = tgc_byte(q.wide ? q.hbuf : q.cnt[15:8]);
      TGC_A_FLAG: rd = tgc_byte({6'h00, q.gif, q.ovf});
      TGC_A_IEN: rd = tgc_byte({5'h00, q.glob, q.gie, q.oie});
      TGC_A_MISC: rd = tgc_byte({7'h00, q.md});
      default: d.pslverr = setup;
    endcase
    d.pready = setup & ~q.pready;
    if (setup) begin
      d.prdata = rd;
      if (!apb_req.pwrite && apb_req.paddr == TGC_A_CNTL && q.wide) begin
        d.hbuf = q.cnt[15:8];
      end
    end else if (!acc_rd) begin
      d.pslverr = 1'b0;
    end

    // ------------------------------------------------------------
    // module disable: timer held in reset
    // ------------------------------------------------------------
    if (q.md) begin
      d = TGC_RST;
      d.md = q.md;
      if (acc_wr && apb_req.paddr == TGC_A_MISC) begin
        d.md = wb[TGC_B_MD];
      end
      d.pready = setup & ~q.pready;
      d.pslverr = setup & ~(apb_req.paddr == TGC_A_MISC);
      // refused registers read as zero
      d.prdata = q.prdata;
      if (setup) begin
        d.prdata = (apb_req.paddr == TGC_A_MISC) ? tgc_byte({7'h00, q.md}) : 32'h00000000;
      end
    end

    // ------------------------------------------------------------
    // time base and interrupt outputs
    // ------------------------------------------------------------
    d.cnt_o = d.cnt;
    d.irq = (d.gif & d.gie) | (d.ovf & d.oie & d.on & d.glob);
    d.wake = d.ovf & d.oie & d.on & sleep_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= TGC_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

endmodule : tgc_timer

// ### rtl/tgc_pkg.sv
// Operation
// - gate level falling edge sets gate flag
// - gate flag works with gate control off
// - count wraps FFFF to 0000, sets overflow
// - flag and enables raise interrupt request
// - overflow flag holds until software clears
// - sleep counting only async external; wakes
// - count presented for capture copies
// - count presented for compare matching
// - special trigger clears count, no flag
// - count write beats special trigger clear
// - module disable holds timer in reset
// - prescaler divides by 1, 2, 4, 8
// - resync bypass picks sync or async
// - system clocks ignore resync bypass bit
// - wide mode gives buffered 16-bit access
// - gate control gates counting when on
// - gate polarity selects active level
// - toggle flip-flop, held clear when off
// - single-pulse mode controls the gate
// - armed bit status, cleared with mode
// - gate level status read-only, always valid
// - five-bit count clock source select
// - low read latches high, low write loads
// - count writes clear prescaler; wide low only
// - armed: start on edge, stop trailing edge
// - five-bit gate source select field
package tgc_pkg;
  localparam logic [7:0] TGC_A_CON = 8'h00;
  localparam logic [7:0] TGC_A_GCON = 8'h04;
  localparam logic [7:0] TGC_A_CLK = 8'h08;
  localparam logic [7:0] TGC_A_GATE = 8'h0C;
  localparam logic [7:0] TGC_A_CNTL = 8'h10;
  localparam logic [7:0] TGC_A_CNTH = 8'h14;
  localparam logic [7:0] TGC_A_FLAG = 8'h18;
  localparam logic [7:0] TGC_A_IEN = 8'h1C;
  localparam logic [7:0] TGC_A_MISC = 8'h20;
  localparam int TGC_B_ON = 0;
  localparam int TGC_B_WIDE = 1;
  localparam int TGC_B_SYNC = 2;
  localparam int TGC_B_PS = 4;
  localparam int TGC_B_GATE_LEVEL_STATUS = 2;
  localparam int TGC_B_ARMED = 3;
  localparam int TGC_B_GATE_SINGLE_PULSE_MODE = 4;
  localparam int TGC_B_GTM = 5;
  localparam int TGC_B_GATE_POLARITY = 6;
  localparam int TGC_B_GE = 7;
  localparam int TGC_B_OVF = 0;
  localparam int TGC_B_GIF = 1;
  localparam int TGC_B_GLOB = 2;
  localparam int TGC_B_MD = 0;
  localparam logic [4:0] TGC_CS_PIN = 5'h00;
  localparam logic [4:0] TGC_CS_FOSC4 = 5'h01;
  localparam logic [4:0] TGC_CS_FOSC = 5'h02;
  localparam logic [4:0] TGC_CS_SOSC = 5'h07;
  localparam logic [4:0] TGC_CS_LAST = 5'h10;
  localparam logic [4:0] TGC_GS_LAST = 5'h1A;
  localparam logic [15:0] TGC_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TGC_CNT_ZERO = 16'h0000;
  localparam logic [1:0] TGC_DIV4_LAST = 2'h3;

  typedef enum logic [1:0] {
    TGC_SP_IDLE = 2'b00,
    TGC_SP_ARMED = 2'b01,
    TGC_SP_RUN = 2'b11
  } tgc_sp_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tgc_apb_req_t;

  typedef struct packed {
    logic [1:0] ps;
    logic sync;
    logic wide;
    logic on;
    logic ge;
    logic gate_polarity;
    logic gate_toggle_mode;
    logic gate_single_pulse_mode;
    logic [4:0] cs;
    logic [4:0] gate_source_field;
    logic [15:0] cnt;
    logic [7:0] hbuf;
    logic [2:0] pre;
    logic [1:0] div4;
    logic clk_s1;
    logic clk_s2;
    logic clk_sprev;
    logic clk_aprev;
    logic gate_polarity_prev;
    logic gt_prev;
    logic tgl;
    tgc_sp_t sp;
    logic gate_level_status;
    logic gif;
    logic ovf;
    logic gie;
    logic oie;
    logic glob;
    logic md;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] cnt_o;
    logic ovf_pulse;
    logic irq;
    logic wake;
  } tgc_state_t;

  localparam tgc_state_t TGC_RST = '0;

  // last prescale count before a tick
  function automatic logic [2:0] tgc_pre_last(input logic [1:0] ps);
    tgc_pre_last = 3'(({3'h0, 1'b1} << ps) - 4'h1);
  endfunction : tgc_pre_last

  function automatic logic [31:0] tgc_byte(input logic [7:0] b);
    tgc_byte = {24'h000000, b};
  endfunction : tgc_byte
endpackage : tgc_pkg

// ### verification/tgc_ccp_model.sv
`timescale 1ns/1ps
module tgc_ccp_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // time base and period
  input wire logic [15:0] count_in,
  input wire logic [15:0] period,
  input wire logic cmp_en,
  // trigger
  output logic special_event
);
  // one pulse per match, count is cleared after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_event <= 1'b0;
    end else begin
      special_event <= cmp_en && count_in == period && !special_event;
    end
  end
endmodule : tgc_ccp_model

// ### verification/tgc_assertions.sv
`timescale 1ns/1ps
module tgc_checker
  import tgc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // bus
  input wire tgc_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // system and time base
  input wire logic sleep_in,
  input wire logic special_event_in,
  input wire logic [15:0] count_out,
  input wire logic overflow_pulse,
  input wire logic irq,
  input wire logic wake
);
  logic wr_acc;
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & pready;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // checks
  // ----
  a_ready_setup: assert property (apb_req.psel && !apb_req.penable && clk_en |=> pready)
    else $error("no pready after setup");
  a_ready_pulse: assert property (pready && clk_en |=> !pready)
    else $error("pready longer than one cycle");
  a_err_read: assert property (pslverr && !apb_req.pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  a_wrap_pulse: assert property (overflow_pulse |-> count_out == 16'h0000 && $past(count_out) == 16'hFFFF)
    else $error("overflow pulse without wrap");
  a_count_step: assert property ($changed(count_out) && !$past(wr_acc) |-> count_out == $past(count_out) + 16'h1 || count_out == 16'h0000)
    else $error("count moved by other than one");
  a_special_clear: assert property (special_event_in && clk_en && !wr_acc |=> count_out == 16'h0000 && !overflow_pulse)
    else $error("special event did not clear");
  a_write_wins: assert property (wr_acc && clk_en && !pslverr && apb_req.paddr == TGC_A_CNTL && special_event_in |=> count_out[7:0] == $past(apb_req.pwdata[7:0]))
    else $error("clear beat the write");
  a_state_frozen: assert property (!clk_en |=> $stable(count_out) && $stable(irq))
    else $error("state moved while frozen");
  a_wake_sleep: assert property (wake && $past(clk_en) |-> $past(sleep_in))
    else $error("wake outside sleep");
  c_wrap: cover property (overflow_pulse);
  c_special: cover property (special_event_in);
  c_refused: cover property (pslverr);
endmodule : tgc_checker

// ### verification/test_gated_16bit_timer_counter.sv
`timescale 1ns/1ps
module test_gated_16bit_timer_counter
  import tgc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic sleep_in = 1'b0;
  logic cmp_en = 1'b0;
  tgc_apb_req_t req = '0;
  logic [16:0] csrc = '0;
  logic [26:0] gsrc = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, ovf_p, irq, wake, sev, err;
  logic [15:0] cnt, c0;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int i;

  always #4 pclk = ~pclk;

  tgc_timer DUT (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .apb_req(req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .count_src_in(csrc),
    .gate_src_in(gsrc),
    .sleep_in(sleep_in),
    .special_event_in(sev),
    .count_out(cnt),
    .overflow_pulse(ovf_p),
    .irq(irq),
    .wake(wake)
  );

  tgc_ccp_model u_ccp (
    .pclk(pclk),
    .presetn(presetn),
    .count_in(cnt),
    .period(16'h0010),
    .cmp_en(cmp_en),
    .special_event(sev)
  );

  task conclude();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask : rdc

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("con", TGC_A_CON, '1, 32'h0);
    rdc("clk", TGC_A_CLK, '1, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    for (i = 0; i < 8; i++) begin
      wr(TGC_A_CLK, i[2] ? 32'(TGC_CS_FOSC4) : 32'(TGC_CS_FOSC));
      wr(TGC_A_CON, 32'h1 | 32'(i[1:0]) << TGC_B_PS);
      wr(TGC_A_CNTL, 32'h0);
      c0 = cnt;
      repeat (64) @(posedge pclk);
      chk("ticks", 32'(64 >> (i[1:0] + 2 * i[2])), 32'(cnt - c0));
    end
    wr(TGC_A_CON, 32'h0);
    wr(TGC_A_CLK, 32'(TGC_CS_PIN));
    for (i = 0; i < 2; i++) begin
      wr(TGC_A_CON, 32'h1 | 32'(i) << TGC_B_SYNC);
      wr(TGC_A_CNTL, 32'h0);
      c0 = cnt;
      repeat (5) begin
        csrc[0] <= 1'b1;
        repeat (2) @(posedge pclk);
        csrc[0] <= 1'b0;
        repeat (2) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      chk("pin edges", 32'h5, 32'(cnt - c0));
    end
    wr(TGC_A_CON, 32'h0);
    wr(TGC_A_CLK, 32'(TGC_CS_FOSC));
    wr(TGC_A_CNTH, 32'hFF);
    wr(TGC_A_CNTL, 32'hF0);
    wr(TGC_A_IEN, 32'h7);
    wr(TGC_A_CON, 32'h1);
    while (ovf_p !== 1'b1) @(posedge pclk);
    sleep_in <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    chk("wake", 32'h1, 32'(wake));
    sleep_in <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("irq held", 32'h1, 32'(irq));
    wr(TGC_A_FLAG, 32'h1);
    chk("irq clear", 32'h0, 32'(irq));
    wr(TGC_A_CON, 32'h0);
    wr(TGC_A_CNTL, 32'h0);
    wr(TGC_A_CLK, 32'(TGC_CS_FOSC4));
    cmp_en <= 1'b1;
    wr(TGC_A_CON, 32'h1);
    c0 = 16'h0000;
    repeat (300) begin
      @(posedge pclk);
      if (cnt > c0) c0 = cnt;
    end
    chk("period", 32'h10, 32'(c0));
    rdc("no ovf", TGC_A_FLAG, 32'h1, 32'h0);
    cmp_en <= 1'b0;
    clk_en <= 1'b0;
    repeat (4) @(posedge pclk);
    clk_en <= 1'b1;
    wr(TGC_A_CON, 32'h2);
    wr(TGC_A_CNTH, 32'hAB);
    wr(TGC_A_CNTL, 32'hCD);
    chk("wide load", 32'hABCD, 32'(cnt));
    wr(TGC_A_CNTH, 32'h12);
    chk("wide hold", 32'hABCD, 32'(cnt));
    rdc("wide lo", TGC_A_CNTL, '1, 32'hCD);
    rdc("wide hi", TGC_A_CNTH, '1, 32'hAB);
    wr(TGC_A_CON, 32'h0);
    wr(TGC_A_CNTH, 32'h0);
    wr(TGC_A_CNTL, 32'h10);
    cmp_en <= 1'b1;
    wr(TGC_A_CNTL, 32'h55);
    chk("write wins", 32'h55, 32'(cnt));
    cmp_en <= 1'b0;
    wr(TGC_A_GCON, 32'h40);
    gsrc[0] <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc("gate_level_status", TGC_A_GCON, 32'h4, 32'h4);
    wr(TGC_A_FLAG, 32'h2);
    rdc("gif clr", TGC_A_FLAG, 32'h2, 32'h0);
    gsrc[0] <= 1'b0;
    repeat (3) @(posedge pclk);
    rdc("gif", TGC_A_FLAG, 32'h2, 32'h2);
    chk("gate irq", 32'h1, 32'(irq));
    wr(TGC_A_CNTL, 32'h0);
    wr(TGC_A_CNTH, 32'h0);
    wr(TGC_A_CLK, 32'(TGC_CS_FOSC));
    wr(TGC_A_GCON, 32'hC0);
    wr(TGC_A_CON, 32'h1);
    repeat (32) @(posedge pclk);
    chk("gated", 32'h0, 32'(cnt));
    gsrc[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    gsrc[0] <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("gate open", 32'hA, 32'(cnt));
    wr(TGC_A_GCON, 32'hD8);
    rdc("armed", TGC_A_GCON, 32'h8, 32'h8);
    wr(TGC_A_GCON, 32'hC0);
    rdc("disarmed", TGC_A_GCON, 32'h8, 32'h0);
    wr(TGC_A_MISC, 32'h1);
    apb(1'b0, TGC_A_CON, 32'h0);
    chk("md err", 32'h1, 32'(err));
    chk("md read", 32'h0, rd);
    wr(TGC_A_MISC, 32'h0);
    chk("md count", 32'h0, 32'(cnt));
    rdc("md reset", TGC_A_CON, '1, 32'h0);
    conclude();
  end
endmodule : test_gated_16bit_timer_counter

bind tgc_timer tgc_checker u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .clk_en(clk_en),
  .apb_req(apb_req),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .sleep_in(sleep_in),
  .special_event_in(special_event_in),
  .count_out(count_out),
  .overflow_pulse(overflow_pulse),
  .irq(irq),
  .wake(wake)
);
